// file: sadc_core.sv
// control, approximation register and read port of the converter
`include "sadc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sadc_core import sadc_pkg::*; #(
	parameter int WIDTH = `SADC_WIDTH,
	parameter int DECIDE_CYC = `SADC_DECIDE_CYC,
	parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic RC,
	input wire logic BYTE_SEL,
	input wire logic COMP_HI,
	output logic [WIDTH-1:0] RESULT_BUS_O,
	output logic [WIDTH-1:0] RESULT_BUS_OE_N,
	output logic BUSY_N,
	output logic HOLD,
	output logic [WIDTH-1:0] DAC_CODE,
	output logic STRM_VALID,
	output logic [WIDTH-1:0] STRM_DATA,
	input wire logic STRM_READY
);
	generate
		if (WIDTH < 2 || WIDTH % 2 != 0) begin : g_bad_width
			$error("width must be even");
		end
		// comparator reaches comp_f four edges late; a shorter step decides on stale data
		if (DECIDE_CYC < 5 || DECIDE_CYC > 255) begin : g_bad_decide
			$error("decision period out of range");
		end
	endgenerate

	localparam int HALF = WIDTH / 2;

	function automatic logic [WIDTH-1:0] to_twos(input logic [WIDTH-1:0] code);
		to_twos = {~code[WIDTH-1], code[WIDTH-2:0]};
	endfunction

	function automatic logic [WIDTH-1:0] order(input logic [WIDTH-1:0] w, input logic swap);
		order = swap ? {w[HALF-1:0], w[WIDTH-1:HALF]} : w;
	endfunction

	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_s3_q;
	logic [3:0] pin_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_s1_q <= `SADC_PIN_RST;
			pin_s2_q <= `SADC_PIN_RST;
			pin_s3_q <= `SADC_PIN_RST;
			pin_q <= `SADC_PIN_RST;
		end else begin
			pin_s1_q <= {COMP_HI, BYTE_SEL, RC, CS_N};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	logic cs_n_f;
	logic rc_f;
	logic bsel_f;
	logic comp_f;
	logic comb_now;
	logic comb_prev_q;
	logic comb_fall;
	assign cs_n_f = pin_q[`SADC_PIN_CS];
	assign rc_f = pin_q[`SADC_PIN_RC];
	assign bsel_f = pin_q[`SADC_PIN_BSEL];
	assign comp_f = pin_q[`SADC_PIN_COMP];
	assign comb_now = cs_n_f | rc_f;
	assign comb_fall = comb_prev_q & ~comb_now;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			comb_prev_q <= 1'b1;
		end else begin
			comb_prev_q <= comb_now;
		end
	end

	// sequencer
	sadc_state_t state_q;
	logic [7:0] step_q;
	logic step_en;
	logic rearm_q;
	logic start;
	logic store_done;
	logic fifo_ready;
	logic [WIDTH-1:0] approx_q;
	logic [WIDTH-1:0] mask_q;
	logic [WIDTH-1:0] latch_q;
	logic busy_n_q;
	logic hold_q;

	assign step_en = step_q == 8'h00;
	// only idle looks at start, so a running conversion cannot be restarted
	assign start = (state_q == ST_IDLE) & ~comb_now & (comb_fall | rearm_q);
	assign store_done = (state_q == ST_STORE) & fifo_ready;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_CLEAR;
					end
				end
				ST_CLEAR: begin
					if (step_en) begin
						state_q <= ST_DECIDE;
					end
				end
				ST_DECIDE: begin
					if (step_en && mask_q[0]) begin
						state_q <= ST_STORE;
					end
				end
				ST_STORE: begin
					// a full fifo stalls here and keeps busy low
					if (fifo_ready) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// decision clock enable from a divider
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			step_q <= 8'(DECIDE_CYC - 1);
		end else if (start || step_en || state_q == ST_IDLE || state_q == ST_STORE) begin
			step_q <= 8'(DECIDE_CYC - 1);
		end else begin
			step_q <= step_q - 8'h01;
		end
	end

	// pulse on the edge that raises busy so a still-low start condition restarts
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rearm_q <= 1'b0;
		end else begin
			rearm_q <= store_done;
		end
	end

	// approximation register and trial bit
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			approx_q <= '0;
			mask_q <= '0;
		end else if (start) begin
			approx_q <= '0;
			mask_q <= '0;
		end else if (state_q == ST_CLEAR && step_en) begin
			mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
			approx_q <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (state_q == ST_DECIDE && step_en) begin
			// comparator high keeps the trial bit; then try the next lower bit
			approx_q <= ((comp_f ? approx_q : (approx_q & ~mask_q)) | (mask_q >> 1));
			mask_q <= mask_q >> 1;
		end
	end

	// output latches load on the same edge that raises busy
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			latch_q <= `SADC_LATCH_RST;
		end else if (store_done) begin
			latch_q <= to_twos(approx_q);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_n_q <= 1'b1;
			hold_q <= 1'b0;
		end else if (start) begin
			busy_n_q <= 1'b0;
			hold_q <= 1'b1;
		end else if (store_done) begin
			busy_n_q <= 1'b1;
			hold_q <= 1'b0;
		end
	end

	// read port
	logic [WIDTH-1:0] bus_q;
	logic oe_n_q;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bus_q <= '0;
			oe_n_q <= 1'b1;
		end else begin
			bus_q <= order(latch_q, bsel_f);
			oe_n_q <= cs_n_f | ~rc_f;
		end
	end

	assign RESULT_BUS_O = bus_q;
	assign RESULT_BUS_OE_N = {WIDTH{oe_n_q}};
	assign BUSY_N = busy_n_q;
	assign HOLD = hold_q;
	assign DAC_CODE = approx_q;

	sadc_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(state_q == ST_STORE),
		.in_data(to_twos(approx_q)),
		.in_ready(fifo_ready),
		.out_valid(STRM_VALID),
		.out_data(STRM_DATA),
		.out_ready(STRM_READY)
	);

	chk_bus_float: assert property (
		@(posedge CLK) disable iff (RST)
		(cs_n_f || !rc_f) |=> (RESULT_BUS_OE_N == {WIDTH{1'b1}}))
		else $error("result bus driven while deselected");

	chk_bus_drive: assert property (
		@(posedge CLK) disable iff (RST)
		(!cs_n_f && rc_f) |=> (RESULT_BUS_OE_N == '0))
		else $error("result bus not driven during read");

	chk_word_order: assert property (
		@(posedge CLK) disable iff (RST)
		(!bsel_f && !store_done) |=> (RESULT_BUS_O == latch_q))
		else $error("word order wrong");

	chk_byte_swap: assert property (
		@(posedge CLK) disable iff (RST)
		(bsel_f && !store_done) |=> (RESULT_BUS_O == {latch_q[HALF-1:0], latch_q[WIDTH-1:HALF]}))
		else $error("bytes not exchanged");

	chk_start_busy: assert property (
		@(posedge CLK) disable iff (RST)
		(comb_fall && busy_n_q) |=> (!BUSY_N && HOLD && approx_q == '0))
		else $error("start did not raise hold and busy");

	chk_busy_run: assert property (
		@(posedge CLK) disable iff (RST)
		$fell(BUSY_N) |-> (!BUSY_N && state_q != ST_IDLE) [*8])
		else $error("busy ended early");

	chk_msb_first: assert property (
		@(posedge CLK) disable iff (RST)
		(state_q == ST_CLEAR && step_en) |=> (mask_q == {1'b1, {(WIDTH-1){1'b0}}}) ##[1:300] (mask_q == '0 || mask_q[WIDTH-2]))
		else $error("decisions not msb first");

	chk_latch_end: assert property (
		@(posedge CLK) disable iff (RST)
		$rose(BUSY_N) |-> (latch_q == to_twos($past(approx_q))))
		else $error("latch not loaded at busy rise");

	chk_no_restart: assert property (
		@(posedge CLK) disable iff (RST)
		(state_q != ST_IDLE && !store_done) |=> !BUSY_N)
		else $error("conversion restarted");

	chk_rearm: assert property (
		@(posedge CLK) disable iff (RST)
		$rose(BUSY_N) ##1 !comb_now |=> !BUSY_N)
		else $error("no back to back conversion");

	chk_hold_busy: assert property (
		@(posedge CLK) disable iff (RST)
		HOLD == !BUSY_N)
		else $error("hold and busy disagree");

	chk_idle_busy: assert property (
		@(posedge CLK) disable iff (RST)
		(state_q == ST_IDLE) |-> BUSY_N)
		else $error("busy low while idle");
endmodule
`default_nettype wire

// file: sadc_defs.svh
// constants of the converter control and read port
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
`define SADC_WIDTH 16
`define SADC_CLK_NS 10
`define SADC_T_CONV_NS 2500
`define SADC_CONV_CYC ((`SADC_T_CONV_NS) / (`SADC_CLK_NS))
`define SADC_STEPS ((`SADC_WIDTH) + 2)
`define SADC_DECIDE_CYC ((`SADC_CONV_CYC) / (`SADC_STEPS))
`define SADC_FIFO_DEPTH 32
`define SADC_LATCH_RST 16'h0000
`define SADC_PIN_RST 4'h3
`define SADC_PIN_CS 0
`define SADC_PIN_RC 1
`define SADC_PIN_BSEL 2
`define SADC_PIN_COMP 3
`endif

// file: sadc_pkg.sv
// types of the converter control and read port
`default_nettype none
package sadc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CLEAR = 4'h2,
		ST_DECIDE = 4'h4,
		ST_STORE = 4'h8
	} sadc_state_t;
endpackage
`default_nettype wire

// file: sadc_fifo.sv
// result fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("fifo depth must be a power of two");
		end
	endgenerate
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic load;
	// honest full: the output register is not counted as space
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign push = in_valid & in_ready;
	assign load = (cnt_q != '0) & (~out_valid_q | out_ready);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (load) begin
				rd_q <= rd_q + 1'b1;
			end
			case ({push, load})
				2'b10: cnt_q <= cnt_q + 1'b1;
				2'b01: cnt_q <= cnt_q - 1'b1;
				default: cnt_q <= cnt_q;
			endcase
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (load) begin
			out_valid_q <= 1'b1;
			out_data_q <= mem_q[rd_q];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: sadc_cmp_model.sv
// comparator and sampler model facing the trial word
`timescale 1ns/1ps
`default_nettype none
module sadc_cmp_model (
	input wire logic clk,
	input wire logic hold,
	input wire logic [15:0] vin,
	input wire logic [15:0] dac_code,
	output logic comp_hi
);
	logic hold_q;
	logic [15:0] smp_q;
	// input frozen on hold so later moves cannot leak into the word
	always @(posedge clk) begin
		hold_q <= hold;
		if (hold && !hold_q)
			smp_q <= vin;
	end
	// keep the trial bit while the held input is at or above it
	assign comp_hi = (smp_q >= dac_code);
endmodule
`default_nettype wire

// file: sar_adc_convert_read_port_tb_top.sv
// testbench of the converter control and read port
`timescale 1ns/1ps
`default_nettype none
module sar_adc_convert_read_port_tb_top;
	logic CLK, RST, CS_N, RC, BYTE_SEL, COMP_HI, BUSY_N, HOLD, STRM_VALID, STRM_READY;
	logic [15:0] RESULT_BUS_O, RESULT_BUS_OE_N, DAC_CODE, STRM_DATA, vin;
	int n_errors = 0;
	int tests_run = 0;
	int i, j;
	logic [15:0] q[$];
	logic [15:0] vins[6] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF, 16'h1234, 16'hA5C3};
	logic bsel[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic [15:0] exps[6] = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h3492, 16'hC325};
	sadc_core #(.DECIDE_CYC(6)) i_dut (.CLK(CLK), .RST(RST), .CS_N(CS_N), .RC(RC), .BYTE_SEL(BYTE_SEL),
		.COMP_HI(COMP_HI), .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE_N(RESULT_BUS_OE_N), .BUSY_N(BUSY_N),
		.HOLD(HOLD), .DAC_CODE(DAC_CODE), .STRM_VALID(STRM_VALID), .STRM_DATA(STRM_DATA),
		.STRM_READY(STRM_READY));
	sadc_cmp_model i_cmp (.clk(CLK), .hold(HOLD), .vin(vin), .dac_code(DAC_CODE), .comp_hi(COMP_HI));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task results();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_busy(input logic lvl, input int lim);
		for (j = 0; j < lim && BUSY_N !== lvl; j++)
			cyc(1);
		if (BUSY_N !== lvl) begin
			chk({15'h0000, BUSY_N}, {15'h0000, lvl});
			results();
		end
	endtask
	// word seen on the bus: two's complement, halves swapped on request
	function automatic logic [15:0] ex(input logic [15:0] v, input logic bs);
		logic [15:0] t;
		t = v ^ 16'h8000;
		return bs ? {t[7:0], t[15:8]} : t;
	endfunction
	// start held 100 ns, well inside the 1 us return window
	task conv_go(input logic [15:0] v);
		vin = v;
		RC = 1'b0;
		cyc(10);
		chk(RESULT_BUS_OE_N, 16'hFFFF);
		chk({15'h0000, BUSY_N}, 16'h0000);
		chk({15'h0000, HOLD}, 16'h0001);
		chk(DAC_CODE, 16'h0000);
		RC = 1'b1;
		q.push_back(ex(v, 1'b0));
	endtask
	task conv(input logic [15:0] v, input logic bs, input logic [15:0] e);
		BYTE_SEL = bs;
		conv_go(v);
		wait_busy(1'b1, 400);
		cyc(8);
		chk({15'h0000, HOLD}, 16'h0000);
		chk(RESULT_BUS_OE_N, 16'h0000);
		chk(RESULT_BUS_O, e);
		cyc(150);
	endtask
	initial begin
		RST = 1'b1;
		CS_N = 1'b0;
		RC = 1'b1;
		BYTE_SEL = 1'b0;
		STRM_READY = 1'b0;
		vin = 16'h0000;
		cyc(20);
		RST = 1'b0;
		cyc(10);
		chk({15'h0000, BUSY_N}, 16'h0001);
		for (i = 0; i < 6; i++)
			conv(vins[i], bsel[i], exps[i]);
		BYTE_SEL = 1'b0;
		CS_N = 1'b1;
		cyc(8);
		chk(RESULT_BUS_OE_N, 16'hFFFF);
		CS_N = 1'b0;
		cyc(8);
		chk({15'h0000, BUSY_N}, 16'h0001);
		chk(RESULT_BUS_OE_N, 16'h0000);
		vin = 16'h0F0F;
		CS_N = 1'b1;
		cyc(8);
		RC = 1'b0;
		cyc(2);
		CS_N = 1'b0;
		cyc(10);
		chk({15'h0000, BUSY_N}, 16'h0000);
		CS_N = 1'b1;
		RC = 1'b1;
		q.push_back(ex(16'h0F0F, 1'b0));
		wait_busy(1'b1, 400);
		cyc(150);
		CS_N = 1'b0;
		cyc(8);
		chk(RESULT_BUS_O, ex(16'h0F0F, 1'b0));
		// second start mid-conversion with a moved input
		conv_go(16'h2222);
		cyc(20);
		vin = 16'h3333;
		RC = 1'b0;
		cyc(10);
		RC = 1'b1;
		wait_busy(1'b1, 400);
		cyc(8);
		chk(RESULT_BUS_O, ex(16'h2222, 1'b0));
		cyc(150);
		chk({15'h0000, BUSY_N}, 16'h0001);
		// start still low at busy rise chains a second conversion
		vin = 16'h5A5A;
		RC = 1'b0;
		cyc(10);
		wait_busy(1'b1, 400);
		wait_busy(1'b0, 5);
		q.push_back(ex(16'h5A5A, 1'b0));
		q.push_back(ex(16'h5A5A, 1'b0));
		RC = 1'b1;
		wait_busy(1'b1, 400);
		cyc(150);
		for (i = 0; q.size() < 33; i++)
			conv(16'h1111 + i[15:0] * 16'h0301, 1'b0, ex(16'h1111 + i[15:0] * 16'h0301, 1'b0));
		// buffer full: the next store must stall with busy low
		conv_go(16'h4321);
		cyc(300);
		chk({15'h0000, BUSY_N}, 16'h0000);
		for (i = 0; i < 34; i++) begin
			for (j = 0; j < 50 && STRM_VALID !== 1'b1; j++)
				cyc(1);
			chk({15'h0000, STRM_VALID}, 16'h0001);
			chk(STRM_DATA, q.pop_front());
			STRM_READY = 1'b1;
			cyc(1);
			STRM_READY = 1'b0;
			cyc(3);
		end
		cyc(5);
		chk({15'h0000, STRM_VALID}, 16'h0000);
		RST = 1'b1;
		cyc(2);
		chk({15'h0000, BUSY_N}, 16'h0001);
		chk(RESULT_BUS_OE_N, 16'hFFFF);
		chk({15'h0000, STRM_VALID}, 16'h0000);
		RST = 1'b0;
		cyc(10);
		chk({15'h0000, BUSY_N}, 16'h0001);
		results();
	end
endmodule
`default_nettype wire
